// File: verilog/e3_tx_framer_pkg.sv
// constants, field layouts and carrier types for the e3 transmit framer
// assumes one byte-wide frame clock shared by all users of the package
package e3_tx_framer_pkg;

  // register map
  localparam logic [7:0] TX_ALARM_CONFIG_ADDR = 8'h30;
  localparam logic [7:0] TX_ALARM_CONFIG_RESET = 8'h00;
  localparam logic [7:0] TX_ALARM_CONFIG_RW_MASK = 8'h17;
  localparam int FAR_END_INDICATION_SELECT_BIT = 0;
  localparam int FORCE_ZERO_SIGNAL_ENABLE_BIT = 1;
  localparam int FORCE_ALL_ONES_ENABLE_BIT = 2;
  localparam int LINK_OCTETS_ROUTE_SELECT_BIT = 4;

  // frame geometry, byte positions counted from the first alignment byte
  localparam logic [9:0] FRAME_LAST_POS = 10'h218;
  localparam logic [9:0] FA1_POS = 10'h000;
  localparam logic [9:0] FA2_POS = 10'h001;
  localparam logic [9:0] EM_POS = 10'h03b;
  localparam logic [9:0] TR_POS = 10'h076;
  localparam logic [9:0] MA_POS = 10'h0b1;
  localparam logic [9:0] NR_POS = 10'h0ec;
  localparam logic [9:0] GC_POS = 10'h127;

  // fixed overhead values
  localparam logic [7:0] FRAMING_ALIGN_ONE_VALUE = 8'hf6;
  localparam logic [7:0] FRAMING_ALIGN_TWO_VALUE = 8'h28;
  localparam logic [7:0] OVERHEAD_IDLE_VALUE = 8'h00;
  localparam logic [7:0] ALL_ONES_VALUE = 8'hff;
  localparam logic [7:0] ALL_ZEROS_VALUE = 8'h00;
  localparam int FAR_END_FAIL_INDICATION_BIT_POS = 7;
  localparam int FAR_END_BLOCK_ERROR_BIT_BIT_POS = 6;

  // input buffer
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum {
    SLOT_PAYLOAD, SLOT_FA1, SLOT_FA2, SLOT_EM, SLOT_TR, SLOT_MA, SLOT_NR, SLOT_GC
  } slot_kind_t;

  // overhead values offered by external equipment, each with its own enable
  typedef struct packed {
    logic ma_valid;
    logic [7:0] ma;
    logic tr_valid;
    logic [7:0] tr;
    logic nr_valid;
    logic [7:0] nr;
    logic gc_valid;
    logic [7:0] gc;
  } overhead_in_t;

  // one outbound byte towards the line encoder
  typedef struct packed {
    logic [7:0] data;
    logic frame_start;
  } line_byte_t;

endpackage

// File: verilog/e3_tx_framer_overhead_alarm.sv
// e3 transmit framer: payload, overhead and alarm multiplexing for one channel
// assumes payload, overhead and link octets come from logic on clk_sys;
// the red alarm level comes from the receive section and is synchronised here
`timescale 1ns/1ns

module e3_tx_framer_overhead_alarm
  import e3_tx_framer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic pay_valid,
  input wire logic [7:0] pay_data,
  output logic pay_ready,
  input wire overhead_in_t oh_in,
  input wire logic link_valid,
  input wire logic [7:0] link_octet,
  output logic link_ack,
  input wire logic rx_red_alarm,
  input wire logic far_end_fail_indication_auto_enable,
  input wire logic far_end_fail_indication_force_zero,
  input wire logic far_end_block_error_bit_value,
  output logic line_valid,
  output line_byte_t line_out,
  input wire logic line_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic [9:0] pos;
    logic [7:0] buf0;
    logic [7:0] buf1;
    logic [1:0] buf_cnt;
    logic in_ready;
    logic out_valid;
    line_byte_t out_byte;
    logic [7:0] bip;
    logic [7:0] bip_acc;
    logic red_s1;
    logic red_s2;
    logic link_ack;
  } state_t;

  state_t s_reg;
  state_t s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // kind of byte carried at a frame position
  function automatic slot_kind_t slot_kind(input logic [9:0] p);
    slot_kind_t k;
    k = SLOT_PAYLOAD;
    if (p == FA1_POS) begin
      k = SLOT_FA1;
    end else if (p == FA2_POS) begin
      k = SLOT_FA2;
    end else if (p == EM_POS) begin
      k = SLOT_EM;
    end else if (p == TR_POS) begin
      k = SLOT_TR;
    end else if (p == MA_POS) begin
      k = SLOT_MA;
    end else if (p == NR_POS) begin
      k = SLOT_NR;
    end else if (p == GC_POS) begin
      k = SLOT_GC;
    end
    return k;
  endfunction

  function automatic logic cfg_bit(input logic [7:0] c, input int b);
    return c[b];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    slot_kind_t kind;
    logic emit_room;
    logic can_emit;
    logic pop;
    logic push;
    logic [1:0] cnt;
    logic [7:0] b;
    logic far_end_fail_indication;
    logic link_to_nr;
    s_next = s_reg;
    kind = slot_kind(s_reg.pos);
    emit_room = 1'b0;
    can_emit = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    cnt = s_reg.buf_cnt;
    b = OVERHEAD_IDLE_VALUE;
    far_end_fail_indication = 1'b0;
    link_to_nr = cfg_bit(s_reg.cfg, LINK_OCTETS_ROUTE_SELECT_BIT);

    s_next.link_ack = 1'b0;
    s_next.red_s1 = rx_red_alarm;
    s_next.red_s2 = s_reg.red_s1;

    // register port
    if (reg_wr && reg_addr == TX_ALARM_CONFIG_ADDR) begin
      s_next.cfg = reg_wdata & TX_ALARM_CONFIG_RW_MASK;
    end
    if (reg_rd) begin
      if (reg_addr == TX_ALARM_CONFIG_ADDR) begin
        s_next.rdata = s_reg.cfg;
      end else begin
        s_next.rdata = 8'h00;
      end
    end

    // output stage accepts a new byte when empty or being drained
    emit_room = !s_reg.out_valid || line_ready;
    can_emit = emit_room && (kind != SLOT_PAYLOAD || s_reg.buf_cnt != 2'h0);

    // byte selection
    case (kind)
      SLOT_PAYLOAD: begin
        b = s_reg.buf0;
      end
      SLOT_FA1: begin
        b = FRAMING_ALIGN_ONE_VALUE;
      end
      SLOT_FA2: begin
        b = FRAMING_ALIGN_TWO_VALUE;
      end
      SLOT_EM: begin
        b = s_reg.bip;
      end
      SLOT_TR: begin
        b = oh_in.tr_valid ? oh_in.tr : OVERHEAD_IDLE_VALUE;
      end
      SLOT_MA: begin
        b = oh_in.ma_valid ? oh_in.ma : OVERHEAD_IDLE_VALUE;
        far_end_fail_indication = cfg_bit(s_reg.cfg, FAR_END_INDICATION_SELECT_BIT) ||
               (far_end_fail_indication_auto_enable && s_reg.red_s2);
        if (far_end_fail_indication_force_zero) begin
          far_end_fail_indication = 1'b0;
        end
        b[FAR_END_FAIL_INDICATION_BIT_POS] = far_end_fail_indication;
        b[FAR_END_BLOCK_ERROR_BIT_BIT_POS] = !cfg_bit(s_reg.cfg, FAR_END_INDICATION_SELECT_BIT) &&
                          far_end_block_error_bit_value;
      end
      SLOT_NR: begin
        b = oh_in.nr_valid ? oh_in.nr : OVERHEAD_IDLE_VALUE;
        if (link_to_nr && link_valid && !s_reg.link_ack) begin
          b = link_octet;
        end
      end
      SLOT_GC: begin
        b = oh_in.gc_valid ? oh_in.gc : OVERHEAD_IDLE_VALUE;
        if (!link_to_nr && link_valid && !s_reg.link_ack) begin
          b = link_octet;
        end
      end
      default: begin
        b = OVERHEAD_IDLE_VALUE;
      end
    endcase

    // alarm overrides, zero signal first
    if (cfg_bit(s_reg.cfg, FORCE_ZERO_SIGNAL_ENABLE_BIT)) begin
      b = ALL_ZEROS_VALUE;
    end else if (cfg_bit(s_reg.cfg, FORCE_ALL_ONES_ENABLE_BIT)) begin
      b = ALL_ONES_VALUE;
    end

    // emit and advance
    if (emit_room) begin
      s_next.out_valid = can_emit;
    end
    if (can_emit) begin
      s_next.out_byte.data = b;
      s_next.out_byte.frame_start = (s_reg.pos == FA1_POS);
      pop = (kind == SLOT_PAYLOAD);
      if ((kind == SLOT_NR && link_to_nr) || (kind == SLOT_GC && !link_to_nr)) begin
        s_next.link_ack = link_valid && !s_reg.link_ack;
      end
      if (s_reg.pos == FRAME_LAST_POS) begin
        s_next.pos = FA1_POS;
        s_next.bip = s_reg.bip_acc ^ b;
        s_next.bip_acc = 8'h00;
      end else begin
        s_next.pos = s_reg.pos + 10'h001;
        s_next.bip_acc = s_reg.bip_acc ^ b;
      end
    end

    // payload input buffer
    push = pay_valid && s_reg.in_ready;
    if (pop) begin
      s_next.buf0 = s_reg.buf1;
      cnt = cnt - 2'h1;
    end
    if (push) begin
      if (cnt == 2'h0) begin
        s_next.buf0 = pay_data;
      end else begin
        s_next.buf1 = pay_data;
      end
      cnt = cnt + 2'h1;
    end
    s_next.buf_cnt = cnt;
    s_next.in_ready = (cnt < BUF_DEPTH);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.cfg <= TX_ALARM_CONFIG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = s_reg.rdata;
  assign pay_ready = s_reg.in_ready;
  assign link_ack = s_reg.link_ack;
  assign line_valid = s_reg.out_valid;
  assign line_out = s_reg.out_byte;

endmodule // e3_tx_framer_overhead_alarm

// File: testbench/e3_tx_framer_overhead_alarm_monitor.sv
// checker: output relations of the e3 framer
// assumes bind to the framer top module
`timescale 1ns/1ns
module e3_tx_framer_overhead_alarm_monitor
  import e3_tx_framer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic line_valid,
  input wire line_byte_t line_out,
  input wire logic line_ready
);
  logic [7:0] cfg_reg;
  logic [7:0] pcfg_reg;
  logic newb_reg;
  wire nb = line_valid && newb_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= 8'h00;
      pcfg_reg <= 8'h00;
      newb_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h30) begin
        cfg_reg <= reg_wdata & 8'h17;
      end
      pcfg_reg <= cfg_reg;
      newb_reg <= line_valid && line_ready;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  a_zero_signal_out: assert property (nb && pcfg_reg[1] |-> line_out.data == 8'h00)
    else $error("zero signal byte not zero");
  a_all_ones_out: assert property (nb && pcfg_reg[2:1] == 2'b10 |-> line_out.data == 8'hff)
    else $error("all ones byte wrong");
  a_align_one: assert property (nb && pcfg_reg[2:1] == 2'b00 && line_out.frame_start
    |-> line_out.data == 8'hf6) else $error("first align byte wrong");
  a_align_two: assert property (line_valid && line_ready && line_out.frame_start
    && line_out.data == 8'hf6 && cfg_reg[2:1] == 2'b00
    |=> line_valid && line_out.data == 8'h28 && !line_out.frame_start)
    else $error("second align byte wrong");
  a_cfg_read: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == $past(cfg_reg))
    else $error("config read wrong");
  a_unmapped_read: assert property (reg_rd && reg_addr != 8'h30 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_read_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_line_holds: assert property (line_valid && !line_ready |=> line_valid && $stable(line_out))
    else $error("line byte dropped while stalled");
  cover property (nb && pcfg_reg[1]);
  cover property (nb && pcfg_reg[2:1] == 2'b10);
  cover property (line_valid && !line_ready && line_out.frame_start);
endmodule // e3_tx_framer_overhead_alarm_monitor

bind e3_tx_framer_overhead_alarm e3_tx_framer_overhead_alarm_monitor u_monitor (.clk_sys, .nrst,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .line_valid, .line_out, .line_ready);

// File: testbench/e3_line_sink.sv
// line encoder sink: ready pattern towards the framer
// assumes the framer clock and reset
`timescale 1ns/1ns
module e3_line_sink (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slow,
  output logic line_ready
);
  logic [1:0] ph_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ph_reg <= 2'h0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
    end
  end
  assign line_ready = !slow || ph_reg == 2'h0;
endmodule // e3_line_sink

// File: testbench/e3_tx_framer_overhead_alarm_tb_top.sv
// bench: register access, frame capture, alarm tests
// assumes the line sink model and the bound checker
`timescale 1ns/1ns
module e3_tx_framer_overhead_alarm_tb_top;
  import e3_tx_framer_pkg::*;
  localparam logic [0:5][7:0] CFG = {8'h00, 8'h01, 8'h01, 8'h10, 8'h00, 8'h00};
  localparam logic [0:5][4:0] CTL = {5'h01, 5'h01, 5'h03, 5'h1c, 5'h10, 5'h00};
  localparam logic [0:5][7:0] MNT = {8'h7c, 8'hbc, 8'h3c, 8'hbc, 8'h3c, 8'h00};
  localparam logic [0:5][7:0] OPR = {8'ha5, 8'ha5, 8'ha5, 8'hc3, 8'ha5, 8'h00};
  localparam logic [0:5][7:0] CHN = {8'h33, 8'h33, 8'h33, 8'h33, 8'hc3, 8'h00};
  localparam logic [0:5][7:0] TRC = {8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'h00};
  localparam logic [0:5] OHV = 6'b111110;
  logic clk_sys, nrst, reg_wr, reg_rd, pay_valid, link_valid, rx_red_alarm, slow;
  logic far_end_fail_indication_auto_enable, far_end_fail_indication_force_zero, far_end_block_error_bit_value, pay_ready, link_ack, line_valid;
  logic line_ready;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pay_data, link_octet, rv, px, cx, em_x, pv;
  overhead_in_t oh_in;
  line_byte_t line_out;
  logic [7:0] ck [0:536];
  int pos = 537, nfr, err_count, num_checks, i, ok, na, ax;
  e3_tx_framer_overhead_alarm u_e3_tx_framer_overhead_alarm (.clk_sys, .nrst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pay_valid, .pay_data, .pay_ready, .oh_in,
    .link_valid, .link_octet, .link_ack, .rx_red_alarm, .far_end_fail_indication_auto_enable,
    .far_end_fail_indication_force_zero, .far_end_block_error_bit_value, .line_valid, .line_out, .line_ready);
  e3_line_sink u_e3_line_sink (.clk_sys, .nrst, .slow, .line_ready);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  task summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'b00;
    repeat (2) @(posedge clk_sys);
    rv = reg_rdata;
  endtask
  task get_frame;
    int n0;
    n0 = nfr;
    for (int k = 0; k < 5000 && nfr == n0; k++) @(negedge clk_sys);
    chk("frame", 8'(nfr != n0), 8'h01);
  endtask
  ////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (pay_valid && pay_ready) begin
      pay_data <= pay_data + 8'h01;
    end
    if (line_valid && line_ready && line_out.frame_start) begin
      pos = 0;
      cx = 8'h00;
      na = 0;
    end
    if (link_ack) begin
      na++;
    end
    if (line_valid && line_ready && pos < 537) begin
      ck[pos] = line_out.data;
      cx ^= line_out.data;
      pos++;
      if (pos == 537) begin
        em_x = px;
        px = cx;
        ax = na;
        nfr++;
      end
    end
  end
  initial begin
    #320000;
    err_count++;
    summarize;
  end
  initial begin
    {nrst, reg_wr, reg_rd, pay_valid, link_valid, rx_red_alarm, slow} = 7'h00;
    {far_end_fail_indication_auto_enable, far_end_fail_indication_force_zero, far_end_block_error_bit_value} = 3'h0;
    {reg_addr, reg_wdata, pay_data, link_octet, px, cx} = 48'h0;
    oh_in = {1'b1, 8'h3c, 1'b1, 8'h5a, 1'b1, 8'ha5, 1'b1, 8'h33};
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    pay_valid <= 1'b1;
    link_octet <= 8'hc3;
    bus(1'b0, 8'h30, 8'h00);
    chk("cfg rst", rv, 8'h00);
    bus(1'b1, 8'h31, 8'h07);
    bus(1'b0, 8'h31, 8'h00);
    chk("unmapped", rv, 8'h00);
    bus(1'b0, 8'h30, 8'h00);
    chk("cfg kept", rv, 8'h00);
    for (i = 0; i < 6; i++) begin
      bus(1'b1, 8'h30, CFG[i]);
      {link_valid, rx_red_alarm, far_end_fail_indication_auto_enable, far_end_fail_indication_force_zero, far_end_block_error_bit_value} <= CTL[i];
      {oh_in.ma_valid, oh_in.tr_valid, oh_in.nr_valid, oh_in.gc_valid} <= {4{OHV[i]}};
      slow <= i[0];
      get_frame;
      get_frame;
      chk("al1", ck[FA1_POS], 8'hf6);
      chk("al2", ck[FA2_POS], 8'h28);
      chk("mon", ck[EM_POS], em_x);
      chk("trc", ck[TR_POS], TRC[i]);
      chk("mnt", ck[MA_POS], MNT[i]);
      chk("opr", ck[NR_POS], OPR[i]);
      chk("chn", ck[GC_POS], CHN[i]);
      chk("ack", 8'(ax), {7'h00, CTL[i][4]});
      ok = 1;
      pv = ck[2];
      for (int p = 3; p < 537; p++) begin
        if (p != EM_POS && p != TR_POS && p != MA_POS && p != NR_POS && p != GC_POS) begin
          ok = (ck[p] === pv + 8'h01) ? ok : 0;
          pv = ck[p];
        end
      end
      chk("pay", 8'(ok), 8'h01);
    end
    @(posedge clk_sys);
    slow <= 1'b0;
    bus(1'b1, 8'h30, 8'h04);
    @(negedge clk_sys);
    chk("ones", line_out.data, 8'hff);
    bus(1'b1, 8'h30, 8'h06);
    @(negedge clk_sys);
    chk("zero", line_out.data, 8'h00);
    bus(1'b1, 8'h30, 8'hff);
    @(negedge clk_sys);
    chk("zero2", line_out.data, 8'h00);
    bus(1'b0, 8'h30, 8'h00);
    chk("cfg ro", rv, 8'h17);
    summarize;
  end
endmodule // e3_tx_framer_overhead_alarm_tb_top
